/* hw/rcs_reset_cause.sv */
// reset cause flags, start-up hold and axi4-lite register slave
`timescale 1ns/100ps
module rcs_reset_cause #(
	parameter int LF_DIV_P     = rcs_pkg::LF_DIV,
	parameter int PWRT_TICKS_P = rcs_pkg::PWRT_TICKS
) (
	input  wire logic           clk,
	input  wire logic           reset_n,
	input  wire logic           ext_reset_pin_n,
	input  wire logic           brownout_det,
	input  wire logic           watchdog_timeout,
	input  wire logic           wake_irq,
	input  wire logic           sleep_cmd,
	input  wire logic [1:0]     brownout_sel,
	input  wire logic           startup_delay_disable,
	input  rcs_pkg::rcs_osc_mode_t osc_mode,
	input  wire logic           aux_crystal_input,
	output logic                core_hold,
	output logic                brownout_enable,
	output logic                ultralow_wake_enable,
	output logic [7:0]          pc_low_byte,
	output logic [4:0]          pc_high_latch,
	input  wire logic [11:0]    s_axi_awaddr,
	input  wire logic           s_axi_awvalid,
	output logic                s_axi_awready,
	input  wire logic [31:0]    s_axi_wdata,
	input  wire logic [3:0]     s_axi_wstrb,
	input  wire logic           s_axi_wvalid,
	output logic                s_axi_wready,
	output logic [1:0]          s_axi_bresp,
	output logic                s_axi_bvalid,
	input  wire logic           s_axi_bready,
	input  wire logic [11:0]    s_axi_araddr,
	input  wire logic           s_axi_arvalid,
	output logic                s_axi_arready,
	output logic [31:0]         s_axi_rdata,
	output logic [1:0]          s_axi_rresp,
	output logic                s_axi_rvalid,
	input  wire logic           s_axi_rready
);
	function automatic logic [2:0] reg_sel(input logic [11:0] a);
		if (a[11:2] == rcs_pkg::CORE_STATUS_IDX)
			return 3'h1;
		else if (a[11:2] == rcs_pkg::POWER_CONTROL_IDX)
			return 3'h2;
		else if (a[11:2] == rcs_pkg::PC_LOW_IDX)
			return 3'h3;
		else if (a[11:2] == rcs_pkg::PC_HIGH_IDX)
			return 3'h4;
		else
			return 3'h0;
	endfunction : reg_sel

	// pin synchroniser: bit 0 pin, bit 1 brown-out detector
	logic [1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
	always_comb begin
		filt_nxt = filt_r;
		for (int i = 0; i < 2; i++) begin
			if (s2_r[i] == s3_r[i])
				filt_nxt[i] = s3_r[i];
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_r   <= 2'h1;
			s2_r   <= 2'h1;
			s3_r   <= 2'h1;
			filt_r <= 2'h1;
		end else begin
			s1_r   <= {brownout_det, ext_reset_pin_n};
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			filt_r <= filt_nxt;
		end
	end

	// bus slave state
	logic [11:0] awaddr_r, awaddr_nxt;
	logic [7:0]  wdata_r, wdata_nxt;
	logic        wstrb_r, wstrb_nxt, aw_have_r, aw_have_nxt;
	logic        w_have_r, w_have_nxt, bvalid_nxt, awready_nxt;
	logic        wready_nxt, arready_nxt, rvalid_nxt;
	logic [1:0]  bresp_nxt, rresp_nxt;
	logic [31:0] rdata_nxt;
	logic        wr_do;
	logic [2:0]  wsel;

	// cause and sequencing state
	logic [7:0] power_control_r, power_control_nxt, status_r, status_nxt, pcl_nxt;
	logic [4:0] pch_nxt;
	logic       asleep_r, asleep_nxt, bor_act_r, boot_r, bor_en_nxt;
	logic       hold_nxt, bor_act, bor_rise, pin_fall, pin_low_r;
	logic       wdt_wake, wdt_rst, irq_wake, any_ev, cold, wake;
	logic       seq_busy;

	assign wsel  = reg_sel(awaddr_r);
	assign wr_do = aw_have_r && w_have_r && !s_axi_bvalid;

	always_comb begin
		awaddr_nxt  = awaddr_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		aw_have_nxt = aw_have_r;
		w_have_nxt  = w_have_r;
		bvalid_nxt  = s_axi_bvalid;
		bresp_nxt   = s_axi_bresp;
		rvalid_nxt  = s_axi_rvalid;
		rresp_nxt   = s_axi_rresp;
		rdata_nxt   = s_axi_rdata;
		if (s_axi_awvalid && s_axi_awready) begin
			awaddr_nxt  = s_axi_awaddr;
			aw_have_nxt = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wdata_nxt  = s_axi_wdata[7:0];
			wstrb_nxt  = s_axi_wstrb[0];
			w_have_nxt = 1'b1;
		end
		if (wr_do) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = (wsel == 3'h0) ? rcs_pkg::RESP_SLVERR :
				rcs_pkg::RESP_OKAY;
		end else if (s_axi_bvalid && s_axi_bready)
			bvalid_nxt = 1'b0;
		if (s_axi_rvalid && s_axi_rready)
			rvalid_nxt = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = rcs_pkg::RESP_OKAY;
			case (reg_sel(s_axi_araddr))
				3'h1: rdata_nxt = {24'h000000, status_r};
				3'h2: rdata_nxt = {24'h000000, power_control_r & rcs_pkg::POWER_CONTROL_MASK};
				3'h3: rdata_nxt = {24'h000000, pc_low_byte};
				3'h4: rdata_nxt = {27'h0000000, pc_high_latch};
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = rcs_pkg::RESP_SLVERR;
				end
			endcase
		end
		// one write and one read in flight; ready drops while holding one
		awready_nxt = !aw_have_nxt && !bvalid_nxt;
		wready_nxt  = !w_have_nxt && !bvalid_nxt;
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			awaddr_r      <= 12'h000;
			wdata_r       <= 8'h00;
			wstrb_r       <= 1'b0;
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= 2'h0;
			s_axi_rdata   <= 32'h00000000;
		end else begin
			awaddr_r      <= awaddr_nxt;
			wdata_r       <= wdata_nxt;
			wstrb_r       <= wstrb_nxt;
			aw_have_r     <= aw_have_nxt;
			w_have_r      <= w_have_nxt;
			s_axi_awready <= awready_nxt;
			s_axi_wready  <= wready_nxt;
			s_axi_bvalid  <= bvalid_nxt;
			s_axi_bresp   <= bresp_nxt;
			s_axi_arready <= arready_nxt;
			s_axi_rvalid  <= rvalid_nxt;
			s_axi_rresp   <= rresp_nxt;
			s_axi_rdata   <= rdata_nxt;
		end
	end

	// detector qualified by the registered enable; sel 00 never fires
	assign bor_act  = filt_r[1] && brownout_enable;
	assign bor_rise = bor_act && !bor_act_r;
	assign pin_fall = !filt_r[0] && !pin_low_r;
	assign wdt_wake = watchdog_timeout && asleep_r && !bor_rise && !pin_fall;
	assign wdt_rst  = watchdog_timeout && !asleep_r && !bor_rise && !pin_fall;
	assign irq_wake = wake_irq && asleep_r && !watchdog_timeout &&
		!bor_rise && !pin_fall;
	assign any_ev   = bor_rise || pin_fall || watchdog_timeout || irq_wake;
	// timers start once the supply is back, so a dip restarts them
	assign cold = boot_r || (bor_act_r && !bor_act);
	assign wake = wdt_wake || irq_wake;

	always_comb begin
		power_control_nxt   = power_control_r;
		status_nxt = status_r;
		pcl_nxt    = pc_low_byte;
		pch_nxt    = pc_high_latch;
		asleep_nxt = asleep_r;
		if (wr_do && wstrb_r) begin
			case (wsel)
				3'h1: status_nxt = (wdata_r & rcs_pkg::STATUS_WR_MASK) |
					(status_r & ~rcs_pkg::STATUS_WR_MASK);
				3'h2: power_control_nxt = wdata_r & rcs_pkg::POWER_CONTROL_MASK;
				3'h3: pcl_nxt = wdata_r;
				3'h4: pch_nxt = wdata_r[4:0];
				default: ;
			endcase
		end
		// hardware events come last so they win over a same-cycle write
		if (bor_rise || pin_fall || wdt_rst) begin
			pcl_nxt = rcs_pkg::PC_LOW_RESET;
			pch_nxt = rcs_pkg::PC_HIGH_RESET;
			status_nxt[7:5] = 3'h0;
			power_control_nxt[rcs_pkg::ULTRALOW_WAKE_ENABLE_BIT] = 1'b0;
			asleep_nxt = 1'b0;
		end
		if (bor_rise) begin
			power_control_nxt[rcs_pkg::BOR_BIT]    = 1'b0;
			power_control_nxt[rcs_pkg::SW_BROWNOUT_ENABLE_BIT] = 1'b1;
			status_nxt[rcs_pkg::TO_BIT]   = 1'b1;
			status_nxt[rcs_pkg::PD_BIT]   = 1'b1;
		end else if (pin_fall) begin
			if (asleep_r) begin
				status_nxt[rcs_pkg::TO_BIT] = 1'b1;
				status_nxt[rcs_pkg::PD_BIT] = 1'b0;
			end
		end else if (wdt_rst) begin
			status_nxt[rcs_pkg::TO_BIT] = 1'b0;
		end else if (wake) begin
			// registers kept; only cause flags and pc move
			if (wdt_wake) begin
				status_nxt[rcs_pkg::TO_BIT] = 1'b0;
				status_nxt[rcs_pkg::PD_BIT] = 1'b0;
			end
			pcl_nxt    = pc_low_byte + 8'h01;
			asleep_nxt = 1'b0;
		end else if (sleep_cmd && !asleep_r) begin
			status_nxt[rcs_pkg::TO_BIT] = 1'b1;
			status_nxt[rcs_pkg::PD_BIT] = 1'b0;
			asleep_nxt = 1'b1;
		end
		case (brownout_sel)
			rcs_pkg::BOR_SEL_OFF:   bor_en_nxt = 1'b0;
			rcs_pkg::BOR_SEL_SW:    bor_en_nxt =
				power_control_nxt[rcs_pkg::SW_BROWNOUT_ENABLE_BIT];
			rcs_pkg::BOR_SEL_AWAKE: bor_en_nxt = !asleep_nxt;
			default:                bor_en_nxt = 1'b1;
		endcase
		// a pin held low or a live brown-out keeps the core parked
		hold_nxt = !filt_r[0] || bor_act || seq_busy || cold || wake;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			power_control_r               <= rcs_pkg::POWER_CONTROL_RESET;
			status_r             <= rcs_pkg::STATUS_RESET;
			pc_low_byte          <= rcs_pkg::PC_LOW_RESET;
			pc_high_latch        <= rcs_pkg::PC_HIGH_RESET;
			asleep_r             <= 1'b0;
			bor_act_r            <= 1'b0;
			pin_low_r            <= 1'b0;
			boot_r               <= 1'b1;
			core_hold            <= 1'b1;
			brownout_enable      <= 1'b0;
			ultralow_wake_enable <= 1'b0;
		end else begin
			power_control_r               <= power_control_nxt;
			status_r             <= status_nxt;
			pc_low_byte          <= pcl_nxt;
			pc_high_latch        <= pch_nxt;
			asleep_r             <= asleep_nxt;
			bor_act_r            <= bor_act;
			pin_low_r            <= !filt_r[0];
			boot_r               <= 1'b0;
			core_hold            <= hold_nxt;
			brownout_enable      <= bor_en_nxt;
			ultralow_wake_enable <= power_control_nxt[rcs_pkg::ULTRALOW_WAKE_ENABLE_BIT];
		end
	end

	rcs_startup_timer #(
		.LF_DIV_P     (LF_DIV_P),
		.PWRT_TICKS_P (PWRT_TICKS_P)
	) u_timer (
		.clk                   (clk),
		.reset_n               (reset_n),
		.start_cold            (cold),
		.start_wake            (wake),
		.osc_mode              (osc_mode),
		.aux_crystal_input     (aux_crystal_input),
		.startup_delay_disable (startup_delay_disable),
		.busy                  (seq_busy)
	);

	a_power_control_unimpl: assert property (@(posedge clk) disable iff (!reset_n)
		(power_control_r & ~rcs_pkg::POWER_CONTROL_MASK) == 8'h00)
		else $error("unimplemented power_control bits set");
	a_por_sticky: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(power_control_r[rcs_pkg::POR_BIT]) |-> $past(wr_do && wsel == 3'h2))
		else $error("power-on flag fell without a write");
	a_bor_flags: assert property (@(posedge clk) disable iff (!reset_n)
		bor_rise |=> !power_control_r[rcs_pkg::BOR_BIT] &&
		status_r[rcs_pkg::TO_BIT] && status_r[rcs_pkg::PD_BIT] &&
		status_r[7:5] == 3'h0)
		else $error("brown-out flag pattern wrong");
	a_wdt_reset: assert property (@(posedge clk) disable iff (!reset_n)
		wdt_rst |=> !status_r[rcs_pkg::TO_BIT] &&
		status_r[rcs_pkg::PD_BIT] == $past(status_r[rcs_pkg::PD_BIT]))
		else $error("watchdog reset flags wrong");
	a_wdt_wake: assert property (@(posedge clk) disable iff (!reset_n)
		wdt_wake |=> !status_r[rcs_pkg::TO_BIT] &&
		!status_r[rcs_pkg::PD_BIT] &&
		pc_low_byte == $past(pc_low_byte) + 8'h01)
		else $error("watchdog wake did not resume at pc plus one");
	a_pin_sleep: assert property (@(posedge clk) disable iff (!reset_n)
		pin_fall && asleep_r && !bor_rise |=> status_r[rcs_pkg::TO_BIT] &&
		!status_r[rcs_pkg::PD_BIT] && pc_low_byte == 8'h00)
		else $error("pin reset in sleep flags wrong");
	a_bor_off: assert property (@(posedge clk) disable iff (!reset_n)
		brownout_sel == rcs_pkg::BOR_SEL_OFF |=> !bor_rise)
		else $error("brown-out fired while disabled");
	a_sw_write: assert property (@(posedge clk) disable iff (!reset_n)
		wr_do && wstrb_r && wsel == 3'h2 && !any_ev |=>
		power_control_r[1:0] == $past(wdata_r[1:0]))
		else $error("flag write did not land next edge");
	a_hold_busy: assert property (@(posedge clk) disable iff (!reset_n)
		seq_busy |=> core_hold)
		else $error("core released while delay runs");
endmodule : rcs_reset_cause

/* hw/rcs_startup_timer.sv */
// start-up delay sequencer: power-up timer then oscillator start-up count
`timescale 1ns/100ps
module rcs_startup_timer #(
	parameter int LF_DIV_P     = rcs_pkg::LF_DIV,
	parameter int PWRT_TICKS_P = rcs_pkg::PWRT_TICKS
) (
	input  wire logic           clk,
	input  wire logic           reset_n,
	input  wire logic           start_cold,
	input  wire logic           start_wake,
	input  rcs_pkg::rcs_osc_mode_t osc_mode,
	input  wire logic           aux_crystal_input,
	input  wire logic           startup_delay_disable,
	output logic                busy
);
	typedef enum {st_idle, st_pwrt, st_ost} rcs_seq_t;
	rcs_seq_t    state_r, state_nxt;
	logic [11:0] div_r, div_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic        busy_nxt, crystal, lf_tick;

	assign crystal = (osc_mode == rcs_pkg::crystal_std_mode) ||
		(osc_mode == rcs_pkg::crystal_fast_mode) ||
		(osc_mode == rcs_pkg::crystal_lowpower_mode && !aux_crystal_input);
	assign lf_tick = (div_r == 12'(LF_DIV_P - 1));

	always_comb begin
		state_nxt = state_r;
		div_nxt   = div_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			st_pwrt: begin
				div_nxt = lf_tick ? 12'h000 : div_r + 12'h001;
				if (lf_tick) begin
					cnt_nxt = cnt_r + 16'h0001;
					if (cnt_r == 16'(PWRT_TICKS_P - 1)) begin
						state_nxt = crystal ? st_ost : st_idle;
						cnt_nxt   = 16'h0000;
					end
				end
			end
			st_ost: begin
				cnt_nxt = cnt_r + 16'h0001;
				if (cnt_r == 16'(rcs_pkg::OST_PERIODS - 1))
					state_nxt = st_idle;
			end
			default: ;
		endcase
		// a new brown-out restarts the whole sequence
		if (start_cold) begin
			div_nxt = 12'h000;
			cnt_nxt = 16'h0000;
			if (!startup_delay_disable)
				state_nxt = st_pwrt;
			else
				state_nxt = crystal ? st_ost : st_idle;
		end else if (start_wake) begin
			cnt_nxt   = 16'h0000;
			state_nxt = crystal ? st_ost : st_idle;
		end
		busy_nxt = (state_nxt != st_idle);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= st_idle;
			div_r   <= 12'h000;
			cnt_r   <= 16'h0000;
			busy    <= 1'b0;
		end else begin
			state_r <= state_nxt;
			div_r   <= div_nxt;
			cnt_r   <= cnt_nxt;
			busy    <= busy_nxt;
		end
	end

	a_pwrt_then_ost: assert property (@(posedge clk) disable iff (!reset_n)
		(state_r == st_pwrt && !start_cold) ##1 state_r == st_ost |->
		$past(cnt_r) == 16'(PWRT_TICKS_P - 1))
		else $error("ost began before the power-up timer ran out");
	a_ost_length: assert property (@(posedge clk) disable iff (!reset_n)
		(state_r == st_ost && cnt_r == 16'(rcs_pkg::OST_PERIODS - 1) &&
		!start_cold && !start_wake) |=> state_r == st_idle)
		else $error("oscillator count did not end after 1024");
endmodule : rcs_startup_timer

/* include/rcs_pkg.sv */
// constants and types for the reset cause and start-up delay block
package rcs_pkg;
	// register indices; byte address is four times the index
	localparam logic [9:0] CORE_STATUS_IDX   = 10'h003;
	localparam logic [9:0] POWER_CONTROL_IDX = 10'h08e;
	localparam logic [9:0] PC_LOW_IDX        = 10'h002;
	localparam logic [9:0] PC_HIGH_IDX       = 10'h00a;
	// power_control fields
	localparam int BOR_BIT    = 0;
	localparam int POR_BIT    = 1;
	localparam int SW_BROWNOUT_ENABLE_BIT = 4;
	localparam int ULTRALOW_WAKE_ENABLE_BIT = 5;
	localparam logic [7:0] POWER_CONTROL_MASK  = 8'h33;
	localparam logic [7:0] POWER_CONTROL_RESET = 8'h10;
	// core_status_flags fields
	localparam int TO_BIT = 4;
	localparam int PD_BIT = 3;
	localparam logic [7:0] STATUS_RESET   = 8'h18;
	localparam logic [7:0] STATUS_WR_MASK = 8'he7;
	localparam logic [4:0] PC_HIGH_RESET  = 5'h00;
	localparam logic [7:0] PC_LOW_RESET   = 8'h00;
	// brownout_sel encodings
	localparam logic [1:0] BOR_SEL_OFF   = 2'h0;
	localparam logic [1:0] BOR_SEL_SW    = 2'h1;
	localparam logic [1:0] BOR_SEL_AWAKE = 2'h2;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// timing
	localparam int CLK_HZ       = 25_000_000;
	localparam int LFOSC_HZ     = 31_000;
	localparam int STARTUP_MS   = 64;
	localparam int LF_DIV       = CLK_HZ / LFOSC_HZ;
	localparam int PWRT_TICKS   = STARTUP_MS * LFOSC_HZ / 1000;
	localparam int OST_PERIODS  = 1024;
	typedef enum logic [2:0] {
		crystal_lowpower_mode,
		crystal_std_mode,
		crystal_fast_mode,
		resistor_cap_mode,
		ext_clock_mode,
		internal_osc_mode
	} rcs_osc_mode_t;
endpackage : rcs_pkg

/* tb/rcs_reset_cause_tb_top.sv */
// self-checking bench for the reset cause and start-up delay block
`timescale 1ns/100ps
module rcs_reset_cause_tb_top;
	localparam int LD = 4;
	localparam int PT = 3;
	localparam logic [11:0] A_ST = 12'h00c;
	localparam logic [11:0] A_PC = 12'h238;
	localparam logic [11:0] A_PL = 12'h008;
	localparam logic [11:0] A_PH = 12'h028;
	logic                   clk = 1'b0;
	logic                   reset_n = 1'b0;
	logic                   ext_reset_pin_n = 1'b1;
	logic                   brownout_det = 1'b0;
	logic                   watchdog_timeout = 1'b0;
	logic                   wake_irq = 1'b0;
	logic                   sleep_cmd = 1'b0;
	logic [1:0]             brownout_sel = 2'h3;
	logic                   startup_delay_disable = 1'b0;
	rcs_pkg::rcs_osc_mode_t osc_mode = rcs_pkg::internal_osc_mode;
	logic                   aux_crystal_input = 1'b0;
	logic                   core_hold, brownout_enable, ultralow_wake_enable;
	logic [7:0]             pc_low_byte;
	logic [4:0]             pc_high_latch;
	logic [11:0]            s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0]            s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]             s_axi_wstrb = 4'h0;
	logic                   s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic                   s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic                   s_axi_rready = 1'b0;
	logic                   s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic                   s_axi_arready, s_axi_rvalid;
	logic [1:0]             s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0]            rdv, seed;
	int                     n_fail = 0;
	int                     checks = 0;
	int                     n;
	// config table for start-up delay sweep
	rcs_pkg::rcs_osc_mode_t cm [7] = '{rcs_pkg::crystal_std_mode,
		rcs_pkg::crystal_fast_mode, rcs_pkg::crystal_lowpower_mode,
		rcs_pkg::crystal_lowpower_mode, rcs_pkg::internal_osc_mode,
		rcs_pkg::resistor_cap_mode, rcs_pkg::ext_clock_mode};
	logic [6:0]             cd = 7'b1011010;
	logic [6:0]             ca = 7'b0000100;

	// small counts keep the power-up timer short
	rcs_reset_cause #(.LF_DIV_P(LD), .PWRT_TICKS_P(PT)) uut (.clk, .reset_n,
		.ext_reset_pin_n, .brownout_det, .watchdog_timeout, .wake_irq,
		.sleep_cmd, .brownout_sel, .startup_delay_disable, .osc_mode,
		.aux_crystal_input, .core_hold, .brownout_enable,
		.ultralow_wake_enable, .pc_low_byte, .pc_high_latch, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	initial begin
		forever #20 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic int dly(input rcs_pkg::rcs_osc_mode_t m,
		input logic dis, input logic aux);
		logic x;
		x = m == rcs_pkg::crystal_std_mode || m == rcs_pkg::crystal_fast_mode
			|| (m == rcs_pkg::crystal_lowpower_mode && !aux);
		return (x ? 1024 : 0) + (dis ? 0 : PT * LD);
	endfunction : dly

	function automatic logic [31:0] st(input logic [2:0] hi, input logic t,
		input logic p, input logic [2:0] lo);
		return {24'h000000, hi, t, p, lo};
	endfunction : st

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize

	task automatic wr(input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] sb);
		logic aw, w;
		int k;
		aw = 1'b0;
		w = 1'b0;
		k = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= sb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			k++;
			if (s_axi_awready === 1'b1 && !aw) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1 && !w) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw && w) && k < 50);
		do begin
			@(posedge clk);
			k++;
		end while (s_axi_bvalid !== 1'b1 && k < 50);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (k >= 50) n_fail++;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [11:0] a);
		int k;
		k = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (s_axi_arready !== 1'b1 && k < 50);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge clk);
			k++;
		end while (s_axi_rvalid !== 1'b1 && k < 50);
		rdv = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (k >= 50) n_fail++;
		@(posedge clk);
	endtask : rd

	// n ends as the number of edges the core stayed held, but never below 4
	task automatic idle();
		n = 0;
		while ((n < 4 || core_hold !== 1'b0) && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000) n_fail++;
		@(posedge clk);
	endtask : idle

	task automatic rst();
		reset_n <= 1'b0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		idle();
	endtask : rst

	// 0 sleep, 1 watchdog, 2 wake irq, 3 pin reset, 4 brown-out
	task automatic ev(input int k);
		case (k)
			0: sleep_cmd <= 1'b1;
			1: watchdog_timeout <= 1'b1;
			2: wake_irq <= 1'b1;
			3: ext_reset_pin_n <= 1'b0;
			default: brownout_det <= 1'b1;
		endcase
		repeat (k > 2 ? 10 : 1) @(posedge clk);
		sleep_cmd <= 1'b0;
		watchdog_timeout <= 1'b0;
		wake_irq <= 1'b0;
		ext_reset_pin_n <= 1'b1;
		brownout_det <= 1'b0;
		idle();
	endtask : ev

	initial begin
		seed = 32'hb3f0;
		rst();
		rd(A_PC);
		chk(rdv, 32'h10);
		rd(A_ST);
		chk(rdv, st(3'h0, 1'b1, 1'b1, 3'h0));
		rd(A_PL);
		chk(rdv, 32'h0);
		rd(A_PH);
		chk(rdv, 32'h0);
		rd(12'h400);
		chk({30'h0, rsp}, {30'h0, rcs_pkg::RESP_SLVERR});
		chk(rdv, 32'h0);
		wr(A_PC, 8'hff, 4'h1);
		rd(A_PC);
		chk(rdv, 32'h33);
		chk(ultralow_wake_enable, 1'b1);
		wr(A_PC, 8'h00, 4'h0);
		rd(A_PC);
		chk(rdv, 32'h33);
		wr(12'h404, 8'h00, 4'h1);
		chk(rsp, rcs_pkg::RESP_SLVERR);
		for (int s = 0; s < 4; s++) begin
			brownout_sel <= s[1:0];
			repeat (3) @(posedge clk);
			chk(brownout_enable, s != 0);
		end
		brownout_sel <= 2'h1;
		wr(A_PC, 8'h23, 4'h1);
		repeat (2) @(posedge clk);
		chk(brownout_enable, 1'b0);
		brownout_sel <= 2'h3;
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			wr(A_PC, seed[7:0], 4'h1);
			rd(A_PC);
			chk(rdv, {24'h0, seed[7:0] & 8'h33});
		end
		wr(A_PC, 8'h13, 4'h1);
		ev(4);
		rd(A_PC);
		chk(rdv, 32'h12);
		wr(A_ST, 8'h07, 4'h1);
		rd(A_ST);
		chk(rdv, st(3'h0, 1'b1, 1'b1, 3'h7));
		wr(A_ST, 8'he7, 4'h1);
		ev(0);
		ev(1);
		rd(A_ST);
		chk(rdv, st(3'h7, 1'b0, 1'b0, 3'h7));
		chk(pc_low_byte, 8'h01);
		rd(A_PC);
		chk(rdv, 32'h12);
		ev(0);
		ev(2);
		rd(A_ST);
		chk(rdv, st(3'h7, 1'b1, 1'b0, 3'h7));
		rd(A_PL);
		chk(rdv, 32'h02);
		ev(1);
		rd(A_ST);
		chk(rdv, st(3'h0, 1'b0, 1'b0, 3'h7));
		chk({pc_high_latch, pc_low_byte}, 13'h0);
		wr(A_ST, 8'he7, 4'h1);
		ev(3);
		rd(A_ST);
		chk(rdv, st(3'h0, 1'b0, 1'b0, 3'h7));
		ev(0);
		ev(2);
		ev(0);
		ev(3);
		rd(A_ST);
		chk(rdv, st(3'h0, 1'b1, 1'b0, 3'h7));
		chk(pc_low_byte, 8'h00);
		rd(A_PC);
		chk(rdv, 32'h12);
		for (int i = 0; i < 7; i++) begin
			osc_mode <= cm[i];
			startup_delay_disable <= cd[i];
			aux_crystal_input <= ca[i];
			rst();
			chk(n >= dly(cm[i], cd[i], ca[i]) - LD
				&& n <= dly(cm[i], cd[i], ca[i]) + LD + 8, 1'b1);
		end
		// wake adds only the oscillator count, never the power-up timer
		osc_mode <= rcs_pkg::crystal_std_mode;
		ev(0);
		ev(1);
		chk(n >= 1020 && n <= 1032, 1'b1);
		summarize();
	end

	initial begin
		#(40 * 60000);
		n_fail++;
		summarize();
	end
endmodule : rcs_reset_cause_tb_top
